// ### src/adcc_top.sv
// Converter control registers with an AHB-Lite slave front end
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module adcc_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Analog side
  input  wire logic [9:0]  analog_code_in,
  output logic [3:0]       analog_channel,
  output logic [1:0]       analog_reference,
  output logic [2:0]       reference_switch,
  output logic             sensor_enable,
  output logic             converter_power,
  // Trigger sources for codes 1 to 7
  input  wire logic [6:0]  trigger_in,
  // Processor interrupt side
  input  wire logic        global_irq_enable,
  input  wire logic        irq_vector_ack,
  output logic             conversion_irq
);
  import adcc_pkg::*;

  //==========================================================================
  // Declarations
  adcc_conv_if conv ();        // Link to the core model

  // Bus pipeline state
  // One transfer in flight at most
  logic        dph_valid_r;    // Data phase pending
  logic        dph_write_r;    // Pending transfer is a write
  logic [7:0]  dph_idx_r;      // Register index of pending transfer
  logic        dph_map_r;      // Address lies in the map
  logic        hreadyout_r;    // Ready towards the bus
  logic [31:0] hrdata_r;       // Read data
  logic        hresp_r;        // Always OKAY

  // Control and status fields
  logic        en_r;           // Converter enable
  logic        ate_r;          // Auto trigger enable
  logic        flag_r;         // Conversion done flag
  logic        ie_r;           // Conversion interrupt enable
  logic [2:0]  div_r;          // Clock divider select

  // Channel, reference and trigger fields
  logic [1:0]  ref_sel_r;      // Reference select
  logic        adj_r;          // Left adjust
  logic [3:0]  chan_sel_r;     // Channel select
  logic [2:0]  trig_sel_r;     // Trigger source select

  // Conversion bookkeeping
  logic [9:0]  result_r;       // Stored result
  logic        lock_r;         // Result frozen after low read
  logic        first_pend_r;   // Next start initialises
  logic        start_r;        // Start pulse to core
  logic        first_r;        // First flag alongside start
  logic        trig_prev_r;    // Trigger level last cycle
  logic        irq_r;          // Interrupt request
  logic        power_r;        // Power output copy

  //==========================================================================
  // Address phase decode
  // Low kilobyte, word aligned
  wire         aph_take = hsel & hready & htrans[1];
  wire         aph_map  = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);

  // Data phase: the wait cycle does the work
  // Writes and read loads land at the wait edge
  wire         act_cyc  = dph_valid_r & ~hreadyout_r;
  wire         wr_cyc   = act_cyc & dph_write_r & dph_map_r;
  wire         rd_cyc   = act_cyc & ~dph_write_r;
  wire [7:0]   wdat     = hwdata[7:0];

  // Register selects
  // Result bytes ignore writes
  wire         wr_cs    = wr_cyc & (dph_idx_r == ADCC_IDX_CTRL_STATUS);
  wire         wr_cr    = wr_cyc & (dph_idx_r == ADCC_IDX_CHAN_REF);
  wire         wr_trig  = wr_cyc & (dph_idx_r == ADCC_IDX_TRIG_SEL);
  wire         rd_low   = rd_cyc & dph_map_r & (dph_idx_r == ADCC_IDX_RESULT_LOW);
  wire         rd_high  = rd_cyc & dph_map_r & (dph_idx_r == ADCC_IDX_RESULT_HIGH);

  //==========================================================================
  // Enable and start decisions
  // Starts refused while busy or pending
  wire         en_nxt   = wr_cs ? wdat[ADCC_CS_EN_BIT] : en_r;
  // Rise marks an initialising start
  wire         en_rise  = en_nxt & ~en_r;
  wire         wr_start = wr_cs & wdat[ADCC_CS_START_BIT];

  wire         trig_lvl = (trig_sel_r == ADCC_TRIG_FREE) ? 1'b0 :
                          trigger_in[3'(trig_sel_r - 3'h1)];
  wire         trig_edge = trig_lvl & ~trig_prev_r;
  // Edges while busy are dropped
  wire         auto_go   = en_r & ate_r & trig_edge;
  // Free run restarts on done
  // free running restart
  wire         free_go   = en_r & ate_r & (trig_sel_r == ADCC_TRIG_FREE) & conv.done;
  wire         start_nxt = (wr_start | auto_go | free_go) & en_nxt & ~conv.busy & ~start_r;

  //==========================================================================
  // Flag set and clear terms
  // vector or written one
  wire         flag_clr = (wr_cs & wdat[ADCC_CS_FLAG_BIT]) | irq_vector_ack;
  wire         flag_nxt = conv.done | (flag_r & ~flag_clr);

  //==========================================================================
  // Read views
  // Built from stored fields
  // start bit shows busy
  wire         busy_rd  = conv.busy | start_r;
  wire [7:0]   cs_rd    = {en_r, busy_rd, ate_r, flag_r, ie_r, div_r};
  wire [7:0]   cr_rd    = {ref_sel_r, adj_r, 1'b0, chan_sel_r};
  wire [7:0]   trig_rd  = {5'h00, trig_sel_r};
  wire [7:0]   low_rd   = adj_r ? {result_r[1:0], 6'h00} : result_r[7:0];
  wire [7:0]   high_rd  = adj_r ? result_r[9:2] : {6'h00, result_r[9:8]};

  // Byte returned for the pending index, zero when unmapped
  wire [7:0]   rd_byte  = !dph_map_r                            ? 8'h00   :
                          (dph_idx_r == ADCC_IDX_CTRL_STATUS)   ? cs_rd   :
                          (dph_idx_r == ADCC_IDX_CHAN_REF)      ? cr_rd   :
                          (dph_idx_r == ADCC_IDX_TRIG_SEL)      ? trig_rd :
                          (dph_idx_r == ADCC_IDX_RESULT_LOW)    ? low_rd  :
                          (dph_idx_r == ADCC_IDX_RESULT_HIGH)   ? high_rd :
                                                                  8'h00;

  //==========================================================================
  // Bus pipeline: capture address phase
  // Taken only while the bus is ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Nothing pending
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_idx_r   <= 8'h00;
      dph_map_r   <= 1'b0;
    end else if (aph_take) begin
      // Latch the transfer
      dph_valid_r <= 1'b1;
      dph_write_r <= hwrite;
      dph_idx_r   <= haddr[9:2];
      dph_map_r   <= aph_map;
    end else if (act_cyc) begin
      // Data phase served
      dph_valid_r <= 1'b0;
    end
  end

  // One wait state per transfer, then ready with data
  // Read data holds until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Ready out of reset
      hreadyout_r <= 1'b1;
      hrdata_r    <= 32'h00000000;
      hresp_r     <= 1'b0;
    end else begin
      // Never an error
      hresp_r <= 1'b0;

      if (aph_take) begin
        // Insert the wait
        hreadyout_r <= 1'b0;
      end else if (act_cyc) begin
        // Release the bus
        hreadyout_r <= 1'b1;
      end
      // Load read byte
      if (rd_cyc) begin
        hrdata_r <= {24'h000000, rd_byte};
      end
    end
  end

  //==========================================================================
  // Control and status register
  // Start bit not stored; it reads busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // All fields clear
      en_r   <= ADCC_CTRL_STATUS_RST[ADCC_CS_EN_BIT];
      ate_r  <= ADCC_CTRL_STATUS_RST[ADCC_CS_ATE_BIT];
      ie_r   <= ADCC_CTRL_STATUS_RST[ADCC_CS_IE_BIT];
      div_r  <= ADCC_CTRL_STATUS_RST[ADCC_CS_DIV_LSB +: 3];
      flag_r <= ADCC_CTRL_STATUS_RST[ADCC_CS_FLAG_BIT];
    end else begin
      en_r   <= en_nxt;
      // Set and clear resolved
      flag_r <= flag_nxt;

      // Plain fields
      if (wr_cs) begin
        ate_r <= wdat[ADCC_CS_ATE_BIT];
        ie_r  <= wdat[ADCC_CS_IE_BIT];
        div_r <= wdat[ADCC_CS_DIV_LSB +: 3];
      end
    end
  end

  // Channel, reference and trigger select registers
  // Bit four is not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // All selections clear
      ref_sel_r  <= ADCC_CHAN_REF_RST[ADCC_CR_REF_LSB +: 2];
      adj_r      <= ADCC_CHAN_REF_RST[ADCC_CR_ADJ_BIT];
      chan_sel_r <= ADCC_CHAN_REF_RST[ADCC_CR_CHAN_LSB +: 4];
      trig_sel_r <= ADCC_TRIG_FREE;
    end else begin
      // Selection byte
      if (wr_cr) begin
        ref_sel_r  <= wdat[ADCC_CR_REF_LSB +: 2];
        adj_r      <= wdat[ADCC_CR_ADJ_BIT];
        chan_sel_r <= wdat[ADCC_CR_CHAN_LSB +: 4];
      end

      // Trigger source byte
      if (wr_trig) begin
        trig_sel_r <= wdat[2:0];
      end
    end
  end

  //==========================================================================
  // Start pulse and initialisation tracking
  // Start lasts one cycle, then busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // No start pending
      start_r      <= 1'b0;
      first_r      <= 1'b0;
      first_pend_r <= 1'b0;
      trig_prev_r  <= 1'b0;
    end else begin
      // Pulse to the core
      start_r     <= start_nxt;
      // Level for edge detection
      trig_prev_r <= trig_lvl;

      // Length chosen with the start
      if (start_nxt) begin
        first_r <= first_pend_r | en_rise;
      end

      if (!en_nxt) begin
        // Disabled
        first_pend_r <= 1'b0;
      end else if (en_rise) begin
        // Freshly enabled
        first_pend_r <= 1'b1;
      end else if (start_r) begin
        // Initialising start used
        first_pend_r <= 1'b0;
      end
    end
  end

  //==========================================================================
  // Result store with two-byte read freeze
  // A result ending under freeze is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Code zero, no freeze
      result_r <= ADCC_CODE_MIN;
      lock_r   <= 1'b0;
    end else begin
      if (conv.done && !lock_r) begin
        result_r <= conv.code;
      end

      if (rd_low) begin
        // Low byte read
        lock_r <= 1'b1;
      end else if (rd_high) begin
        // High byte releases
        lock_r <= 1'b0;
      end
    end
  end

  //==========================================================================
  // Interrupt request and power output
  // Both registered for clean outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Quiet after reset
      irq_r   <= 1'b0;
      power_r <= 1'b0;
    end else begin
      irq_r   <= flag_r & ie_r & global_irq_enable;

      // Copy of the enable bit
      power_r <= en_nxt;
    end
  end

  //==========================================================================
  // Core model and its link
  // Core holds selection while busy
  assign conv.start    = start_r;
  assign conv.first    = first_r;
  assign conv.enable   = en_r;
  assign conv.div      = div_r;
  assign conv.chan_req = chan_sel_r;
  assign conv.ref_req  = ref_sel_r;
  assign conv.sample   = analog_code_in;

  adcc_core u_core (
    .hclk    (hclk),
    .hresetn (hresetn),
    .conv    (conv)
  );

  //==========================================================================
  // Outputs
  // Bus side
  assign hreadyout        = hreadyout_r;
  assign hrdata           = hrdata_r;
  assign hresp            = hresp_r;
  // Analog side
  assign analog_channel   = conv.chan;
  assign analog_reference = conv.refsel;
  assign reference_switch = conv.ref_onehot;
  assign sensor_enable    = conv.sensor_en;
  // Power and interrupt
  assign converter_power  = power_r;
  assign conversion_irq   = irq_r;

endmodule : adcc_top
`default_nettype wire

// ### src/adcc_pkg.sv
// Constants, bit positions and types shared by the converter control logic
//==========================================================================
package adcc_pkg;

  //==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] ADCC_IDX_RESULT_LOW  = 8'h78;
  localparam logic [7:0] ADCC_IDX_RESULT_HIGH = 8'h79;
  localparam logic [7:0] ADCC_IDX_CTRL_STATUS = 8'h7A;
  localparam logic [7:0] ADCC_IDX_CHAN_REF    = 8'h7C;
  localparam logic [7:0] ADCC_IDX_TRIG_SEL    = 8'h7D;

  //==========================================================================
  // Field positions
  localparam int ADCC_CS_EN_BIT    = 7;
  localparam int ADCC_CS_START_BIT = 6;
  localparam int ADCC_CS_ATE_BIT   = 5;
  localparam int ADCC_CS_FLAG_BIT  = 4;
  localparam int ADCC_CS_IE_BIT    = 3;
  localparam int ADCC_CS_DIV_LSB   = 0;
  localparam int ADCC_CR_REF_LSB   = 6;
  localparam int ADCC_CR_ADJ_BIT   = 5;
  localparam int ADCC_CR_CHAN_LSB  = 0;

  //==========================================================================
  // Reset values
  localparam logic [7:0] ADCC_CTRL_STATUS_RST = 8'h00;
  localparam logic [7:0] ADCC_CHAN_REF_RST    = 8'h00;
  localparam logic [9:0] ADCC_CODE_MIN        = 10'h000;
  localparam logic [9:0] ADCC_CODE_MAX        = 10'h3FF;

  //==========================================================================
  // Channel and reference encodings
  localparam logic [3:0] ADCC_CHAN_SENSOR  = 4'h8;
  localparam logic [3:0] ADCC_CHAN_BANDGAP = 4'hE;
  localparam logic [3:0] ADCC_CHAN_GROUND  = 4'hF;
  localparam logic [1:0] ADCC_REF_EXTERNAL = 2'h0;
  localparam logic [1:0] ADCC_REF_SUPPLY   = 2'h1;
  localparam logic [1:0] ADCC_REF_BANDGAP  = 2'h3;
  localparam logic [2:0] ADCC_TRIG_FREE    = 3'h0;

  //==========================================================================
  // Conversion lengths in converter clock cycles
  localparam logic [4:0] ADCC_FIRST_CYCLES  = 5'h19;
  localparam logic [4:0] ADCC_NORMAL_CYCLES = 5'h0D;

  // Converter sequencer states
  typedef enum logic {
    ADCC_IDLE,
    ADCC_CONV
  } adcc_state_t;

endpackage : adcc_pkg

// ### src/adcc_conv_if.sv
// Link between the register front end and the converter core model
`timescale 1ns/10ps
`default_nettype none
interface adcc_conv_if;
  logic       start;      // Start pulse
  logic       first;      // Start is an initialising conversion
  logic       enable;     // Converter powered
  logic [2:0] div;        // Prescaler code
  logic [3:0] chan_req;   // Channel asked by software
  logic [1:0] ref_req;    // Reference asked by software
  logic [9:0] sample;     // Analog code presented to the core
  logic       busy;       // Conversion running
  logic       done;       // Completion pulse
  logic [9:0] code;       // Converted code
  logic [3:0] chan;       // Channel held at the converter
  logic [1:0] refsel;     // Reference held at the converter
  logic       sensor_en;  // Temperature sensor enabled
  logic [2:0] ref_onehot; // External, supply, bandgap

  modport ctrl (output start, first, enable, div, chan_req, ref_req, sample,
                input busy, done, code, chan, refsel, sensor_en, ref_onehot);
  modport core (input start, first, enable, div, chan_req, ref_req, sample,
                output busy, done, code, chan, refsel, sensor_en, ref_onehot);
endinterface : adcc_conv_if
`default_nettype wire

// ### src/adcc_core.sv
// Converter core model: prescaler, conversion timing and selection hold
`timescale 1ns/10ps
`default_nettype none
module adcc_core (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Front end link
  adcc_conv_if.core conv
);
  import adcc_pkg::*;

  //==========================================================================
  // Prescaler, sequencer and selection registers
  logic [6:0]  pre_cnt_r;   // Divider count
  logic [6:0]  pre_lim;     // Terminal count
  logic        tick;        // One converter clock
  adcc_state_t state_r;     // Sequencer state
  logic [4:0]  cyc_left_r;  // Converter cycles remaining
  logic        done_r;      // Completion pulse
  logic [9:0]  code_r;      // Captured code
  logic [3:0]  chan_r;      // Held channel
  logic [1:0]  ref_r;       // Held reference
  logic        sensor_r;    // Sensor enable
  logic [2:0]  ref_oh_r;    // Reference switches

  // Codes 0 and 1 divide by two, then doubling
  assign pre_lim = (conv.div <= 3'h1) ? 7'h01 : 7'((8'h01 << conv.div) - 8'h01);
  assign tick    = (pre_cnt_r >= pre_lim);

  // Divider runs only while powered
  // prescaler divide
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r <= 7'h00;
    end else if (!conv.enable || tick) begin
      pre_cnt_r <= 7'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 7'h01;
    end
  end

  //==========================================================================
  // Conversion sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= ADCC_IDLE;
      cyc_left_r <= 5'h00;
      done_r     <= 1'b0;
      code_r     <= ADCC_CODE_MIN;
    end else if (!conv.enable) begin
      state_r    <= ADCC_IDLE;
      cyc_left_r <= 5'h00;
      done_r     <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ADCC_IDLE: begin
          if (conv.start) begin
            state_r    <= ADCC_CONV;
            cyc_left_r <= conv.first ? ADCC_FIRST_CYCLES : ADCC_NORMAL_CYCLES;
          end
        end
        ADCC_CONV: begin
          if (tick && (cyc_left_r == 5'h01)) begin
            state_r <= ADCC_IDLE;
            done_r  <= 1'b1;
            code_r  <= conv.sample;
          end else if (tick) begin
            cyc_left_r <= cyc_left_r - 5'h01;
          end
        end
        default: begin
          state_r <= ADCC_IDLE;
        end
      endcase
    end
  end

  //==========================================================================
  // Selection follows software only while idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_r   <= 4'h0;
      ref_r    <= 2'h0;
      sensor_r <= 1'b0;
      ref_oh_r <= 3'h0;
    end else if (state_r == ADCC_IDLE) begin
      chan_r   <= conv.chan_req;
      ref_r    <= conv.ref_req;
      sensor_r <= (conv.chan_req == ADCC_CHAN_SENSOR);
      ref_oh_r <= {conv.ref_req == ADCC_REF_BANDGAP, conv.ref_req == ADCC_REF_SUPPLY,
                   conv.ref_req == ADCC_REF_EXTERNAL};
    end
  end

  assign conv.busy       = (state_r == ADCC_CONV);
  assign conv.done       = done_r;
  assign conv.code       = code_r;
  assign conv.chan       = chan_r;
  assign conv.refsel     = ref_r;
  assign conv.sensor_en  = sensor_r;
  assign conv.ref_onehot = ref_oh_r;

endmodule : adcc_core
`default_nettype wire

// ### sim/adcc_analog_model.sv
// Behavioural analog source facing the converter selection outputs
`timescale 1ns/10ps
`default_nettype none
module adcc_analog_model (
  // Selection held at the converter
  input  wire logic [3:0] analog_channel,
  input  wire logic [1:0] analog_reference,
  input  wire logic       sensor_enable,
  input  wire logic       converter_power,
  // Code presented to the converter
  output logic      [9:0] analog_code_in
);
  logic [9:0] level; // Code of the selected input
  // ground, bandgap, sensor and pin levels
  assign level = (analog_channel == 4'hF) ? 10'h000 :
                 (analog_channel == 4'hE) ? 10'h3FF :
                 (analog_channel == 4'h8) ? (sensor_enable ? 10'h13A : 10'h000) :
                 {analog_channel, analog_reference, 4'h5};
  // Unpowered core shows no valid code
  assign analog_code_in = converter_power ? level : ~level;
endmodule : adcc_analog_model
`default_nettype wire

// ### sim/adcc_props.sv
// Port checker for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcc_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic [3:0]  analog_channel,
  input wire logic [1:0]  analog_reference,
  input wire logic [2:0]  reference_switch,
  input wire logic        sensor_enable,
  input wire logic        converter_power,
  input wire logic        global_irq_enable,
  input wire logic        conversion_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic       take = hsel && hready && htrans[1]; // Transfer accepted
  wire logic [7:0] idx  = haddr[9:2];                  // Register index
  a_wait_state: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("wait state wrong");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_unused_bit: assert property (take && !hwrite && idx == 8'h7C |-> ##2 hrdata[4] == 1'b0)
    else $error("unused bit read high");
  a_unmapped_zero: assert property (take && !hwrite && !(idx inside {8'h78, 8'h79, 8'h7A, 8'h7C, 8'h7D})
    |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_power_follow: assert property (take && hwrite && idx == 8'h7A |-> ##2 converter_power == $past(hwdata[7]))
    else $error("power not following enable");
  a_sensor_route: assert property ($past(hresetn, 2) && $stable(analog_channel)
    |-> sensor_enable == (analog_channel == 4'h8))
    else $error("sensor enable wrong");
  a_ref_decode: assert property ($past(hresetn, 2) && $stable(analog_reference) |-> reference_switch ==
    (analog_reference == 2'h0 ? 3'h1 : analog_reference == 2'h1 ? 3'h2 : analog_reference == 2'h3 ? 3'h4 : 3'h0))
    else $error("reference switch wrong");
  a_irq_gated: assert property (!global_irq_enable |=> !conversion_irq)
    else $error("irq without global enable");
endmodule : adcc_props
bind adcc_top adcc_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hrdata, .hresp, .analog_channel, .analog_reference, .reference_switch, .sensor_enable,
  .converter_power, .global_irq_enable, .conversion_irq);
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import adcc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, analog_reference;
  logic [9:0]  analog_code_in;
  logic [3:0]  analog_channel;
  logic [2:0]  reference_switch;
  logic [6:0]  trigger_in;
  logic        sensor_enable, converter_power, global_irq_enable, irq_vector_ack, conversion_irq;
  int          failures, cmp_count, n;
  adcc_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .analog_code_in, .analog_channel, .analog_reference, .reference_switch,
    .sensor_enable, .converter_power, .trigger_in, .global_irq_enable, .irq_vector_ack, .conversion_irq);
  adcc_analog_model u_model (.analog_channel, .analog_reference, .sensor_enable, .converter_power,
    .analog_code_in);
  //==========================================================================
  // Clock
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Cycle count compare against a window
  task automatic chk_rng(input int v, input int lo, input int hi);
    cmp_count++;
    if (v < lo || v > hi) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, v, lo);
    end
  endtask : chk_rng
  // One AHB-Lite single transfer, read data into rd
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    logic r;
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {22'h0, idx, 2'h0};
    do begin @(negedge hclk); r = hreadyout; @(posedge hclk); end while (r !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin @(negedge hclk); r = hreadyout; rd = hrdata; @(posedge hclk); end while (r !== 1'b1);
  endtask : bus
  task automatic settle;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
  endtask : settle
  // Count cycles until the interrupt line rises
  task automatic wait_irq;
    n = 0;
    do begin @(negedge hclk); n++; end while (conversion_irq !== 1'b1 && n < 400);
  endtask : wait_irq
  task automatic vec_ack;
    @(posedge hclk) irq_vector_ack <= 1'b1;
    @(posedge hclk) irq_vector_ack <= 1'b0;
    @(posedge hclk);
  endtask : vec_ack
  //==========================================================================
  // Scenarios
  task automatic t_reset;
    bus(1'b0, 8'h7A, 8'h0); chk(rd, 32'h0);
    bus(1'b0, 8'h7C, 8'h0); chk(rd, 32'h0);
    bus(1'b0, 8'h40, 8'h0); chk(rd, 32'h0);
  endtask : t_reset
  task automatic t_select;
    logic [2:0] sw [4];
    sw = '{3'h1, 3'h2, 3'h0, 3'h4};
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 8'h7C, {r[1:0], 6'h3F});
      bus(1'b0, 8'h7C, 8'h0); chk(rd, {24'h0, r[1:0], 6'h2F});
      settle;
      chk({29'h0, reference_switch}, {29'h0, sw[r]});
      chk({30'h0, analog_reference}, {30'h0, r[1:0]});
      chk({28'h0, analog_channel}, 32'hF);
    end
    bus(1'b1, 8'h7C, 8'hC8);
    settle;
    chk({31'h0, sensor_enable}, 32'h1);
  endtask : t_select
  task automatic t_convert;
    @(posedge hclk) global_irq_enable <= 1'b1;
    bus(1'b1, 8'h7C, 8'h43);
    bus(1'b1, 8'h7A, 8'hCA);
    wait_irq; chk_rng(n, 98, 112);
    bus(1'b0, 8'h7A, 8'h0); chk(rd, 32'h9A);
    bus(1'b0, 8'h78, 8'h0); chk(rd, 32'hD5);
    bus(1'b0, 8'h79, 8'h0); chk(rd, 32'h00);
    bus(1'b1, 8'h7C, 8'h63);
    bus(1'b0, 8'h78, 8'h0); chk(rd, 32'h40);
    bus(1'b0, 8'h79, 8'h0); chk(rd, 32'h35);
    vec_ack;
    bus(1'b0, 8'h7A, 8'h0); chk(rd, 32'h8A);
    bus(1'b1, 8'h7A, 8'hCA);
    wait_irq; chk_rng(n, 50, 62);
    bus(1'b1, 8'h7A, 8'h9A);
    bus(1'b0, 8'h7A, 8'h0); chk(rd, 32'h8A);
    settle; chk({31'h0, conversion_irq}, 32'h0);
  endtask : t_convert
  task automatic t_hold;
    bus(1'b1, 8'h7C, 8'h43);
    bus(1'b1, 8'h7A, 8'hCA);
    bus(1'b1, 8'h7C, 8'h45);
    @(negedge hclk) chk({28'h0, analog_channel}, 32'h3);
    wait_irq; settle;
    chk({28'h0, analog_channel}, 32'h5);
    vec_ack;
    bus(1'b0, 8'h78, 8'h0); chk(rd, 32'hD5);
    bus(1'b1, 8'h7A, 8'hCA);
    wait_irq;
    bus(1'b0, 8'h79, 8'h0); chk(rd, 32'h00);
    vec_ack;
  endtask : t_hold
  task automatic t_abort;
    bus(1'b1, 8'h7A, 8'hC2);
    bus(1'b1, 8'h7A, 8'h02);
    settle; chk({31'h0, converter_power}, 32'h0);
    repeat (120) @(posedge hclk);
    bus(1'b0, 8'h7A, 8'h0); chk(rd, 32'h02);
  endtask : t_abort
  task automatic t_auto;
    bus(1'b1, 8'h7D, 8'h01);
    bus(1'b1, 8'h7A, 8'hAA);
    @(posedge hclk) trigger_in <= 7'h01;
    wait_irq; chk_rng(n, 98, 114);
    @(posedge hclk) trigger_in <= 7'h00;
    vec_ack;
    bus(1'b1, 8'h7D, 8'h00);
    wait_irq; chk_rng(n, 400, 400);
    bus(1'b1, 8'h7A, 8'hEA);
    wait_irq; chk_rng(n, 50, 62);
    vec_ack;
    wait_irq; chk_rng(n, 44, 62);
    bus(1'b1, 8'h7A, 8'h00);
  endtask : t_auto
  //==========================================================================
  // Verdict and end of run
  task automatic stop_test;
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    #160000;
    failures++;
    stop_test;
  end
  initial begin
    {hresetn, hsel, hwrite, global_irq_enable, irq_vector_ack} = 5'h08;
    {haddr, hwdata, htrans, trigger_in} = '0;
    failures = 0;
    cmp_count = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_select;
    t_convert;
    t_hold;
    t_abort;
    t_auto;
    stop_test;
  end
endmodule : testbench
`default_nettype wire
